/* hw/mdp_pkg.sv */
// Purpose: Shared constants and types for the MAC-side data port.
// Assumes: Core clock is the 25 MHz reference, period 40 ns.
// Notes: Timing counts are derived from times and the core clock period.
package mdp_pkg;

  // ==========================================================================
  // Timing
  localparam int MCLK_PERIOD_NS = 40;
  localparam int LINK_HALF_NS = 160;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int JAB_MS = 20;
  localparam int JAB_CYC = (JAB_MS * 1000000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int UNJAB_MS = 250;
  localparam int UNJAB_CYC = (UNJAB_MS * 1000000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SQE_NS = 1000;
  localparam int SQE_CYC = SQE_NS / MCLK_PERIOD_NS;

  typedef logic [23:0] mdp_cnt_type;
  typedef logic [3:0] mdp_div_type;
  typedef logic [7:0] mdp_sqe_type;
  typedef logic [1:0] mdp_strap_type;
  localparam mdp_strap_type STRAP_WAIT = 2'h2;

  // ==========================================================================
  // Receive symbol kinds from the line decoder
  localparam int KIND_W = 3;
  localparam logic [2:0] K_DATA = 3'h0;
  localparam logic [2:0] K_PRE = 3'h1;
  localparam logic [2:0] K_SFD = 3'h2;
  localparam logic [2:0] K_SSD = 3'h3;
  localparam logic [2:0] K_ESD = 3'h4;
  localparam logic [2:0] K_IDLE = 3'h5;
  localparam logic [2:0] K_ERR = 3'h6;

  localparam logic [3:0] RXD_ERR = 4'hE;
  localparam logic [3:0] RXD_IDLE = 4'h0;
  localparam int RX_W = 7;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Synchronised pin vector positions
  localparam int PIN_W = 13;
  localparam int P_TXD = 0;
  localparam int P_TXEN = 4;
  localparam int P_TXER = 5;
  localparam int P_REF = 6;
  localparam int P_CAR = 7;
  localparam int P_STRAP = 8;
  localparam int P_SPD = 9;
  localparam int P_FD = 10;
  localparam int P_LINK = 11;
  localparam int P_ANEG = 12;

  typedef enum logic [1:0] {RX_IDLE, RX_CARRIER, RX_DATA} mdp_rx_state_type;

endpackage : mdp_pkg

/* hw/mdp_mac_data_port.sv */
// Purpose: MAC-facing data port of a 10/100 transceiver, nibble and di-bit modes.
// Assumes: Line decoder hands over classified receive symbols on the core clock.
// Notes: The link clock is derived from the core clock; REF_CLK is sampled.
`timescale 1ns/1ps

// ============================================================================
// Receive buffer
module mdp_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk, // Core clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_wr_valid, // Write request
  output logic o_wr_ready, // Room available
  input wire logic [WIDTH-1:0] i_wr_data, // Write word
  output logic o_rd_valid, // Word available
  input wire logic i_rd_ready, // Read accept
  output logic [WIDTH-1:0] o_rd_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  wire push = i_wr_valid & o_wr_ready;
  wire pop = o_rd_valid & i_rd_ready;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign o_rd_valid = (cnt_q != '0);
  assign o_rd_data = mem_q[rp_q];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wp_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      o_wr_ready <= 1'b0;
    end else begin
      wp_q <= push ? wp_q + AW'(1) : wp_q;
      rp_q <= pop ? rp_q + AW'(1) : rp_q;
      cnt_q <= cnt_d;
      o_wr_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : mdp_fifo

module mdp_mac_data_port #(
  parameter int JAB_CYC = mdp_pkg::JAB_CYC,
  parameter int UNJAB_CYC = mdp_pkg::UNJAB_CYC
) (
  input wire logic i_mclk, // Core clock, reference input
  input wire logic i_nrst, // Async reset, active low
  input wire logic [3:0] i_txd, // Transmit data pins
  input wire logic i_txen, // Transmit enable pin
  input wire logic i_txer, // Transmit error pin
  input wire logic i_ref_clk, // Reduced-mode reference clock pin
  input wire logic i_strap_rmii, // Reduced-mode strap level
  input wire logic i_speed100, // Link speed 100 when high
  input wire logic i_full_duplex, // Full duplex when high
  input wire logic i_link_up, // Link established
  input wire logic i_aneg_en, // Auto-negotiation enabled
  input wire logic i_carrier, // Carrier detect from line
  input wire logic i_line_rx_valid, // Decoded receive symbol valid
  input wire logic [2:0] i_line_rx_kind, // Symbol kind
  input wire logic [3:0] i_line_rx_data, // Symbol data nibble
  output logic o_line_rx_ready, // Receive buffer has room
  output logic o_txc, // Transmit clock out
  output logic o_rxc, // Receive clock out
  output logic [3:0] o_rxd, // Receive data
  output logic o_rxdv, // Receive data valid
  output logic o_rxer, // Receive error
  output logic o_crs, // Carrier sense
  output logic o_col, // Collision
  output logic o_crs_dv, // Reduced-mode carrier and valid
  output logic o_line_tx_valid, // Transmit nibble pulse
  output logic [3:0] o_line_tx_data, // Transmit nibble
  output logic o_line_tx_err, // Send error code group
  output logic o_line_tx_en, // Line transmitter active
  output logic o_tx10_enabled, // 10BaseT transmitter not jabbered
  output logic o_rxc_from_line, // RXC uses recovered clock
  output logic o_rmii_mode // Reduced mode latched
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // ==========================================================================
  // Pin synchronisers
  logic [mdp_pkg::PIN_W-1:0] pin_s1_q;
  logic [mdp_pkg::PIN_W-1:0] pin_s2_q;
  wire [mdp_pkg::PIN_W-1:0] pin_raw = {i_aneg_en, i_link_up, i_full_duplex, i_speed100,
    i_strap_rmii, i_carrier, i_ref_clk, i_txer, i_txen, i_txd};
  genvar gi;
  generate
    for (gi = 0; gi < mdp_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate
  wire [3:0] txd_s = pin_s2_q[mdp_pkg::P_TXD +: 4];
  wire txen_s = pin_s2_q[mdp_pkg::P_TXEN];
  wire txer_s = pin_s2_q[mdp_pkg::P_TXER];
  wire ref_s = pin_s2_q[mdp_pkg::P_REF];
  wire car_s = pin_s2_q[mdp_pkg::P_CAR];
  wire ten = !pin_s2_q[mdp_pkg::P_SPD];
  wire fd_s = pin_s2_q[mdp_pkg::P_FD];

  // ==========================================================================
  // Strap capture after reset release
  logic [1:0] strap_cnt_q;
  logic rmii_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_cnt_q <= '0;
      rmii_q <= 1'b0;
    end else if (strap_cnt_q < mdp_pkg::STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else if (strap_cnt_q == mdp_pkg::STRAP_WAIT) begin
      // Counter parks past the capture point so the strap is taken once per reset
      strap_cnt_q <= strap_cnt_q + 2'h1;
      rmii_q <= pin_s2_q[mdp_pkg::P_STRAP];
    end
  end

  // ==========================================================================
  // Link clock: own divider in MII, sampled REF_CLK edges in reduced mode
  mdp_pkg::mdp_div_type div_q;
  logic clk_q;
  logic ref_p_q;
  wire div_end = (div_q == mdp_pkg::mdp_div_type'(mdp_pkg::LINK_HALF_CYC - 1));
  wire ref_rise = ref_s & !ref_p_q;
  wire tx_tick = rmii_q ? ref_rise : (div_end & !clk_q);
  wire rx_tick = rmii_q ? ref_rise : (div_end & clk_q);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= '0;
      clk_q <= 1'b0;
      ref_p_q <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : div_q + mdp_pkg::mdp_div_type'(1);
      clk_q <= div_end ? !clk_q : clk_q;
      ref_p_q <= ref_s;
    end
  end
  assign o_txc = clk_q;
  assign o_rxc = clk_q;

  // ==========================================================================
  // Jabber and SQE
  mdp_pkg::mdp_cnt_type jcnt_q;
  mdp_pkg::mdp_sqe_type sqe_q;
  logic jab_q;
  logic txen_p_q;
  wire tx_fall = txen_p_q & !txen_s;
  wire tx_ok = !(ten & jab_q);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      jab_q <= 1'b0;
      jcnt_q <= '0;
    end else if (!ten) begin
      jab_q <= 1'b0;
      jcnt_q <= '0;
    end else if (jab_q ? txen_s : !txen_s) begin
      jcnt_q <= '0;
    end else if (!jab_q && jcnt_q == mdp_pkg::mdp_cnt_type'(JAB_CYC)) begin
      jab_q <= 1'b1;
      jcnt_q <= '0;
    end else if (jab_q && jcnt_q == mdp_pkg::mdp_cnt_type'(UNJAB_CYC)) begin
      jab_q <= 1'b0;
      jcnt_q <= '0;
    end else begin
      jcnt_q <= jcnt_q + mdp_pkg::mdp_cnt_type'(1);
    end
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      txen_p_q <= 1'b0;
      sqe_q <= '0;
      o_col <= 1'b0;
      o_tx10_enabled <= 1'b1;
    end else begin
      txen_p_q <= txen_s;
      if (tx_fall && ten && !jab_q) begin
        sqe_q <= mdp_pkg::mdp_sqe_type'(mdp_pkg::SQE_CYC);
      end else if (sqe_q != '0) begin
        sqe_q <= sqe_q - mdp_pkg::mdp_sqe_type'(1);
      end
      o_col <= !rmii_q & ((!fd_s & txen_s & car_s) | (ten & jab_q) | (sqe_q != '0));
      o_tx10_enabled <= tx_ok;
    end
  end

  // ==========================================================================
  // Transmit path
  logic tx_half_q;
  logic [1:0] tx_lo_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_half_q <= 1'b0;
      tx_lo_q <= '0;
      o_line_tx_valid <= 1'b0;
      o_line_tx_data <= '0;
      o_line_tx_err <= 1'b0;
      o_line_tx_en <= 1'b0;
    end else begin
      o_line_tx_valid <= 1'b0;
      o_line_tx_en <= txen_s & tx_ok;
      if (tx_tick && rmii_q) begin
        if (!txen_s) begin
          tx_half_q <= 1'b0;
        end else if (!tx_half_q) begin
          tx_lo_q <= txd_s[1:0];
          tx_half_q <= 1'b1;
        end else begin
          o_line_tx_valid <= tx_ok;
          o_line_tx_data <= {txd_s[1:0], tx_lo_q};
          o_line_tx_err <= 1'b0;
          tx_half_q <= 1'b0;
        end
      end else if (tx_tick) begin
        o_line_tx_valid <= txen_s & tx_ok;
        o_line_tx_data <= txd_s;
        o_line_tx_err <= txer_s & txen_s;
      end
    end
  end

  // ==========================================================================
  // Receive path
  logic rx_valid;
  logic [mdp_pkg::RX_W-1:0] rx_head;
  logic rx_half_q;
  mdp_pkg::mdp_rx_state_type st_q;
  mdp_pkg::mdp_rx_state_type st_d;
  logic crs_d;
  logic dv_d;
  logic er_d;
  wire [2:0] kind = rx_head[mdp_pkg::RX_W-1 -: mdp_pkg::KIND_W];
  wire [3:0] nib = (kind == mdp_pkg::K_ERR) ? mdp_pkg::RXD_ERR : rx_head[3:0];
  wire is_nib = (kind == mdp_pkg::K_DATA) | (kind == mdp_pkg::K_PRE) |
    (kind == mdp_pkg::K_SFD) | (kind == mdp_pkg::K_ERR);
  wire rx_take = rx_tick & rx_valid;
  wire rx_split = rmii_q & is_nib & !rx_half_q;
  wire [1:0] dibit = rx_half_q ? nib[3:2] : nib[1:0];
  wire show = dv_d | (kind == mdp_pkg::K_ERR);
  wire [3:0] rxd_d = !show ? mdp_pkg::RXD_IDLE : (rmii_q ? {2'h0, dibit} : nib);

  mdp_fifo #(.WIDTH(mdp_pkg::RX_W), .DEPTH(mdp_pkg::FIFO_DEPTH)) u_rx_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_wr_valid(i_line_rx_valid),
    .o_wr_ready(o_line_rx_ready),
    .i_wr_data({i_line_rx_kind, i_line_rx_data}),
    .o_rd_valid(rx_valid),
    .i_rd_ready(rx_take & !rx_split),
    .o_rd_data(rx_head)
  );

  always_comb begin
    st_d = st_q;
    crs_d = o_crs;
    dv_d = o_rxdv;
    er_d = rx_tick ? 1'b0 : o_rxer;
    if (rx_take) begin
      case (kind)
        mdp_pkg::K_SSD: begin
          if (!ten) begin
            st_d = mdp_pkg::RX_CARRIER;
            crs_d = 1'b1;
          end
        end
        mdp_pkg::K_PRE: begin
          if (ten) begin
            st_d = mdp_pkg::RX_CARRIER;
            crs_d = 1'b1;
          end else if (st_q != mdp_pkg::RX_IDLE) begin
            st_d = mdp_pkg::RX_DATA;
            dv_d = 1'b1;
          end
        end
        mdp_pkg::K_SFD: begin
          if (st_q != mdp_pkg::RX_IDLE) begin
            st_d = mdp_pkg::RX_DATA;
            dv_d = 1'b1;
          end
        end
        mdp_pkg::K_ERR: begin
          er_d = 1'b1;
        end
        mdp_pkg::K_ESD: begin
          st_d = mdp_pkg::RX_IDLE;
          crs_d = 1'b0;
          dv_d = 1'b0;
        end
        mdp_pkg::K_IDLE: begin
          if (st_q != mdp_pkg::RX_IDLE) begin
            st_d = mdp_pkg::RX_IDLE;
            crs_d = 1'b0;
            dv_d = 1'b0;
            er_d = !ten;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= mdp_pkg::RX_IDLE;
      rx_half_q <= 1'b0;
      o_crs <= 1'b0;
      o_rxdv <= 1'b0;
      o_rxer <= 1'b0;
      o_rxd <= '0;
    end else begin
      st_q <= st_d;
      o_crs <= crs_d;
      o_rxdv <= dv_d;
      o_rxer <= er_d;
      if (rx_take) begin
        rx_half_q <= rx_split;
        o_rxd <= rxd_d;
      end else if (rmii_q && !o_crs_dv) begin
        o_rxd <= mdp_pkg::RXD_IDLE;
      end
    end
  end

  // ==========================================================================
  // Reduced-mode carrier/valid and RXC source
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_crs_dv <= 1'b0;
      o_rxc_from_line <= 1'b0;
    end else begin
      if (!rmii_q) begin
        o_crs_dv <= 1'b0;
      end else if (car_s) begin
        o_crs_dv <= 1'b1;
      end else if (rx_tick && !rx_valid) begin
        o_crs_dv <= 1'b0;
      end
      o_rxc_from_line <= ten ? (car_s | (st_q != mdp_pkg::RX_IDLE)) :
        (pin_s2_q[mdp_pkg::P_LINK] | pin_s2_q[mdp_pkg::P_ANEG]);
    end
  end
  assign o_rmii_mode = rmii_q;

  // ==========================================================================
  // Checks
  property p_jab_col;
    jab_q && ten && !rmii_q |=> o_col;
  endproperty
  a_jab_col: assert property (p_jab_col) else $error("jabber without collision");

  property p_unjab;
    $fell(jab_q) && $past(ten) |-> !$past(txen_s) && $past(jcnt_q) == mdp_pkg::mdp_cnt_type'(UNJAB_CYC);
  endproperty
  a_unjab: assert property (p_unjab) else $error("jabber released early");

  property p_sqe;
    tx_fall && ten && !jab_q && !rmii_q |-> ##2 o_col;
  endproperty
  a_sqe: assert property (p_sqe) else $error("no SQE pulse after packet");

  property p_col;
    !rmii_q && !fd_s && txen_s && car_s |=> o_col;
  endproperty
  a_col: assert property (p_col) else $error("collision missed");

  property p_rx_err;
    rx_take && kind == mdp_pkg::K_ERR && !rmii_q |=> o_rxer && o_rxd == mdp_pkg::RXD_ERR;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("error symbol not flagged");

  property p_false_end;
    rx_take && kind == mdp_pkg::K_IDLE && st_q != mdp_pkg::RX_IDLE && !ten
      |=> !o_crs && o_rxer ##1 o_rxer;
  endproperty
  a_false_end: assert property (p_false_end) else $error("idle end not flagged");

  property p_ssd;
    rx_take && kind == mdp_pkg::K_SSD && !ten |=> o_crs;
  endproperty
  a_ssd: assert property (p_ssd) else $error("carrier sense not raised");

  property p_crs_dv;
    rmii_q && car_s |=> o_crs_dv;
  endproperty
  a_crs_dv: assert property (p_crs_dv) else $error("CRS_DV late");

  property p_rxd_edge;
    !rmii_q && $changed(o_rxd) |-> $past(rx_tick);
  endproperty
  a_rxd_edge: assert property (p_rxd_edge) else $error("RXD moved off falling edge");

  property p_tx_gap;
    rmii_q && o_line_tx_valid |-> $past(txen_s);
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("di-bit taken while TX_EN low");

endmodule : mdp_mac_data_port

/* sim/mdp_mac_model.sv */
// Purpose: Behavioural MAC that drives the transmit pins of the data port.
// Assumes: Pins change 1 ns after the edge of the clock that the MAC uses.
// Notes: Expected line nibbles are noted in txq for the bench.
`timescale 1ns/1ps
module mdp_mac_model (
  input wire logic i_txc, // MII transmit clock
  input wire logic i_ref_clk, // Reduced-mode reference clock
  input wire logic i_rmii, // Reduced mode active
  output logic [3:0] o_txd, // Transmit data
  output logic o_txen, // Transmit enable
  output logic o_txer // Transmit error
);
  logic [4:0] txq[$];

  initial begin
    o_txd = 4'h0;
    o_txen = 1'h0;
    o_txer = 1'h0;
  end

  // ==========
  // One unit, launched just after the edge of the clock in use
  task automatic unit(input logic en, input logic er, input logic [3:0] d);
    if (i_rmii === 1'h1) @(posedge i_ref_clk);
    else @(posedge i_txc);
    #1;
    o_txen = en;
    o_txer = er;
    o_txd = d;
  endtask : unit

  // Frame of n nibbles from w; junk goes on the data pins after the frame in reduced mode, zero in MII
  task automatic send(input logic [31:0] w, input int n, input int err_at,
                      input logic [1:0] junk);
    logic [3:0] nib;
    logic er;
    for (int i = 0; i < n; i++) begin
      nib = w[4*i +: 4];
      er = (i == err_at) && (i_rmii !== 1'h1);
      txq.push_back({er, nib});
      if (i_rmii === 1'h1) begin
        unit(1'h1, 1'h0, {2'h0, nib[1:0]});
        unit(1'h1, 1'h0, {2'h0, nib[3:2]});
      end else begin
        unit(1'h1, er, nib);
      end
    end
    unit(1'h0, 1'h0, (i_rmii === 1'h1) ? {2'h0, junk} : 4'h0);
  endtask : send

  // Hold enable at a level for n transmit clocks, data idle
  task automatic hold(input logic en, input int n);
    unit(en, 1'h0, 4'h0);
    repeat (n) @(posedge i_txc);
    #1;
  endtask : hold
endmodule : mdp_mac_model

/* sim/mdp_mac_data_port_test.sv */
// Purpose: Self-checking bench for the MAC-side data port.
// Assumes: Short jabber counts; link clock of 320 ns.
// Notes: Drivers note results in queues; watchers compare them.
`timescale 1ns/1ps
module mdp_mac_data_port_test;
  logic i_mclk, i_nrst, i_ref_clk, i_strap_rmii, i_speed100, i_full_duplex, i_link_up;
  logic i_aneg_en, i_carrier, i_line_rx_valid, i_txen, i_txer, o_line_rx_ready, o_txc, o_rxc;
  logic o_rxdv, o_rxer, o_crs, o_col, o_crs_dv, o_line_tx_valid, o_line_tx_err, o_line_tx_en;
  logic o_tx10_enabled, o_rxc_from_line, o_rmii_mode;
  logic [2:0] i_line_rx_kind;
  logic [3:0] i_line_rx_data, i_txd, o_rxd, o_line_tx_data;
  int n_mismatch = 0;
  int compares = 0;
  int k;
  logic [31:0] seed = 32'h63FC9FCF;
  logic [4:0] rxq[$];
  logic cq[$];
  logic tx_chk = 1'h0;
  logic crs_q = 1'h0;
  logic dv_q = 1'h0;
  logic saw_full = 1'h0;

  mdp_mac_data_port #(.JAB_CYC(50), .UNJAB_CYC(200)) uut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_txd(i_txd), .i_txen(i_txen), .i_txer(i_txer),
    .i_ref_clk(i_ref_clk), .i_strap_rmii(i_strap_rmii), .i_speed100(i_speed100),
    .i_full_duplex(i_full_duplex), .i_link_up(i_link_up), .i_aneg_en(i_aneg_en),
    .i_carrier(i_carrier), .i_line_rx_valid(i_line_rx_valid), .i_line_rx_kind(i_line_rx_kind),
    .i_line_rx_data(i_line_rx_data), .o_line_rx_ready(o_line_rx_ready), .o_txc(o_txc),
    .o_rxc(o_rxc), .o_rxd(o_rxd), .o_rxdv(o_rxdv), .o_rxer(o_rxer), .o_crs(o_crs),
    .o_col(o_col), .o_crs_dv(o_crs_dv), .o_line_tx_valid(o_line_tx_valid),
    .o_line_tx_data(o_line_tx_data), .o_line_tx_err(o_line_tx_err),
    .o_line_tx_en(o_line_tx_en), .o_tx10_enabled(o_tx10_enabled),
    .o_rxc_from_line(o_rxc_from_line), .o_rmii_mode(o_rmii_mode));

  mdp_mac_model mac (.i_txc(o_txc), .i_ref_clk(i_ref_clk), .i_rmii(o_rmii_mode),
    .o_txd(i_txd), .o_txen(i_txen), .o_txer(i_txer));

  initial begin
    i_mclk = 1'h0;
    forever #20 i_mclk = ~i_mclk;
  end

  initial begin
    i_ref_clk = 1'h0;
    #7;
    forever #160 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic fail(input string m);
    n_mismatch++;
    $display("[FAIL] %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'h1) fail(m);
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : settle

  task automatic end_of_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // ==========
  // Watchers
  always @(posedge i_mclk) begin
    crs_q <= o_crs;
    dv_q <= o_crs_dv;
    if (i_line_rx_valid === 1'h1 && o_line_rx_ready === 1'h0) saw_full <= 1'h1;
    if (o_line_tx_valid === 1'h1 && tx_chk === 1'h1) begin
      compares++;
      if (mac.txq.size() == 0) fail("unexpected line nibble");
      else if ({o_line_tx_err, o_line_tx_data} !== mac.txq.pop_front()) fail("line nibble");
    end
    if (i_nrst === 1'h1 && crs_q === 1'h1 && o_crs === 1'h0 && cq.size() > 0) begin
      compares++;
      if (o_rxer !== cq.pop_front()) fail("rxer at carrier drop");
    end
    if (o_rmii_mode === 1'h1) begin
      compares++;
      if ((dv_q === 1'h0 && o_crs_dv === 1'h0 && o_rxd !== 4'h0) || o_rxd[3:2] !== 2'h0)
        fail("rxd not idle");
    end
  end

  always @(posedge o_rxc) begin
    if (o_rxdv === 1'h1 && o_rmii_mode === 1'h0) begin
      compares++;
      if (rxq.size() == 0) fail("unexpected rx nibble");
      else if ({o_rxer, o_rxd} !== rxq.pop_front() || o_crs !== 1'h1) fail("rx nibble");
    end
  end

  // ==========
  // Drivers
  task automatic do_reset(input logic s);
    i_nrst = 1'h0;
    i_strap_rmii = s;
    settle(2);
    chk({o_rxdv, o_crs, o_col, o_crs_dv, o_line_tx_valid, o_tx10_enabled} === 6'h01, "reset");
    i_nrst = 1'h1;
    settle(6);
  endtask : do_reset

  task automatic push(input logic [2:0] kind, input logic [3:0] d);
    i_line_rx_valid = 1'h1;
    i_line_rx_kind = kind;
    i_line_rx_data = d;
    for (int j = 0; j < 200; j++) begin
      @(posedge i_mclk);
      if (o_line_rx_ready === 1'h1) break;
    end
    #1;
  endtask : push

  task automatic rx_frame(input logic f100, input int n, input int err_at, input logic abort);
    logic [3:0] d;
    if (f100) push(mdp_pkg::K_SSD, 4'h0);
    for (int i = 0; i < 2; i++) begin
      push(mdp_pkg::K_PRE, 4'h5);
      if (f100) rxq.push_back(5'h05);
    end
    if (!f100) begin
      push(mdp_pkg::K_SFD, 4'h5);
      rxq.push_back(5'h05);
    end
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d = seed[3:0];
      push((i == err_at) ? mdp_pkg::K_ERR : mdp_pkg::K_DATA, d);
      rxq.push_back((i == err_at) ? {1'h1, mdp_pkg::RXD_ERR} : {1'h0, d});
    end
    push(abort ? mdp_pkg::K_IDLE : mdp_pkg::K_ESD, 4'h0);
    i_line_rx_valid = 1'h0;
    cq.push_back(abort);
    for (int i = 0; i < 2000 && cq.size() > 0; i++) @(posedge i_mclk);
    #1;
    chk(cq.size() == 0 && rxq.size() == 0, "rx frame incomplete");
  endtask : rx_frame

  initial begin
    #2_000_000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    {i_speed100, i_full_duplex, i_link_up, i_aneg_en} = 4'hF;
    {i_carrier, i_line_rx_valid, i_line_rx_kind, i_line_rx_data} = 9'h000;
    do_reset(1'h0);
    chk(o_rmii_mode === 1'h0, "default mode");
    tx_chk = 1'h1;
    seed = lfsr(seed);
    mac.send(seed, 8, 3, 2'h0);
    settle(40);
    chk(mac.txq.size() == 0, "tx nibbles lost");
    rx_frame(1'h1, 6, 2, 1'h0);
    rx_frame(1'h1, 4, -1, 1'h1);
    i_speed100 = 1'h0;
    settle(4);
    rx_frame(1'h0, 20, -1, 1'h0);
    chk(saw_full === 1'h1, "fifo never full");
    i_speed100 = 1'h1;
    settle(6);
    chk(o_rxc_from_line === 1'h1, "rxc from line");
    {i_link_up, i_aneg_en} = 2'h0;
    settle(6);
    chk(o_rxc_from_line === 1'h0, "rxc from master");
    {i_link_up, i_aneg_en} = 2'h3;
    tx_chk = 1'h0;
    i_full_duplex = 1'h0;
    i_carrier = 1'h1;
    mac.hold(1'h1, 2);
    chk(o_col === 1'h1, "collision");
    i_full_duplex = 1'h1;
    settle(6);
    chk(o_col === 1'h0, "no collision in full duplex");
    mac.hold(1'h0, 2);
    i_carrier = 1'h0;
    i_speed100 = 1'h0;
    settle(6);
    tx_chk = 1'h1;
    mac.send(seed, 4, -1, 2'h0);
    for (k = 0; k < 20 && o_col !== 1'h1; k++) @(posedge i_mclk);
    for (k = 0; k < 40 && o_col === 1'h1; k++) @(posedge i_mclk);
    #1;
    chk(k == mdp_pkg::SQE_CYC, "sqe pulse length");
    tx_chk = 1'h0;
    mac.hold(1'h1, 5);
    chk(o_tx10_enabled === 1'h1 && o_line_tx_en === 1'h1, "early jabber");
    mac.hold(1'h1, 5);
    chk(o_tx10_enabled === 1'h0 && o_col === 1'h1 && o_line_tx_en === 1'h0, "jabber");
    mac.hold(1'h0, 20);
    chk(o_tx10_enabled === 1'h0 && o_col === 1'h1, "early release");
    mac.hold(1'h0, 12);
    chk(o_tx10_enabled === 1'h1 && o_col === 1'h0, "release");
    i_speed100 = 1'h1;
    do_reset(1'h1);
    chk(o_rmii_mode === 1'h1, "reduced mode");
    tx_chk = 1'h1;
    seed = lfsr(seed);
    mac.send(seed, 6, -1, 2'h3);
    settle(80);
    chk(mac.txq.size() == 0, "di-bit nibbles lost");
    i_carrier = 1'h1;
    settle(4);
    chk(o_crs_dv === 1'h1, "crs_dv rise");
    push(mdp_pkg::K_SSD, 4'h0);
    push(mdp_pkg::K_PRE, 4'h5);
    push(mdp_pkg::K_DATA, seed[7:4]);
    push(mdp_pkg::K_ESD, 4'h0);
    i_line_rx_valid = 1'h0;
    i_carrier = 1'h0;
    for (k = 0; k < 200 && o_crs_dv !== 1'h0; k++) @(posedge i_mclk);
    chk(o_crs_dv === 1'h0, "crs_dv stuck");
    end_of_test;
  end
endmodule : mdp_mac_data_port_test
